/* File: rtl/pst_status_irq.sv */
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Summary status, interrupt control and event status bank
// ****************************************************************
module pst_status_irq (
  input wire logic clk_i, // 50 MHz
  input wire logic reset_i, // Synchronous, active high
  // Register port
  input wire logic [pst_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [pst_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [pst_pkg::DATA_W-1:0] reg_rdata_o,
  // Live conditions from the transceiver core, same clock
  input wire logic jabber_i, // Basic status jabber flag
  input wire logic link_i, // Basic status link flag
  input wire logic an_complete_i,
  input wire logic loopback_i,
  input wire logic full_duplex_i, // From negotiation or forced mode
  input wire logic speed10_i, // From negotiation or forced mode
  input wire logic energy_i, // Energy detect state
  input wire logic fcar_half_i, // False carrier counter half full
  input wire logic rxerr_half_i, // Receive error counter half full
  // Shared power-down / interrupt pin, active low both ways
  input wire logic powerdown_irq_pin_i,
  output logic powerdown_irq_pin_o,
  output logic powerdown_irq_pin_oe_o,
  output logic powerdown_req_o // Power-down requested via the pin
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [pst_pkg::CTL_W-1:0] ctrl_reg; // Interrupt control bits 2:0
  logic [pst_pkg::CTL_W-1:0] ctrl_next;
  logic [pst_pkg::EVT_N-1:0] evt_en_reg; // Per-event enables
  logic [pst_pkg::EVT_N-1:0] evt_en_next;
  logic [pst_pkg::EVT_N-1:0] evt_stat_reg; // Sticky event flags
  logic [pst_pkg::EVT_N-1:0] evt_stat_next;
  logic [5:0] prev_reg; // Previous levels for change detection
  logic [5:0] prev_next;
  logic [pst_pkg::EVT_N-1:0] evt_vec; // One-cycle event pulses
  logic irq_pend_reg; // Internal interrupt pending
  logic irq_pend_next;
  logic [pst_pkg::DATA_W-1:0] rdata_reg;
  logic [pst_pkg::DATA_W-1:0] rdata_next;
  logic pin_out_reg;
  logic pin_out_next;
  logic pin_oe_reg;
  logic pin_oe_next;
  logic pd_req_reg;
  logic pd_req_next;
  logic pin_sync; // Pin level after two flops
  logic evt_read; // Read of event status this cycle
  logic [1:0] half_reg; // Bit 1 false carrier, bit 0 receive error
  logic [1:0] half_next;

  // Address match used by both read and write decode
  function automatic logic hit(input logic [pst_pkg::ADDR_W-1:0] a,
                               input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  // Pin idles high, so a reset value of one avoids a false power-down
  pst_sync2 #(
    .WIDTH(1),
    .INIT(1'b1)
  ) u_pin_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i(powerdown_irq_pin_i),
    .sync_o(pin_sync)
  );

  // ****************************************************************
  // Event detection
  // ****************************************************************
  // Level changes become one-cycle pulses; half-full and completion on rise
  always_comb begin
    prev_next = {energy_i, link_i, speed10_i, full_duplex_i, an_complete_i,
                 fcar_half_i ^ rxerr_half_i};
    evt_vec = '0;
    evt_vec[pst_pkg::EVT_ENERGY] = energy_i ^ prev_reg[5];
    evt_vec[pst_pkg::EVT_LINK] = link_i ^ prev_reg[4];
    evt_vec[pst_pkg::EVT_SPEED] = speed10_i ^ prev_reg[3];
    evt_vec[pst_pkg::EVT_DUPLEX] = full_duplex_i ^ prev_reg[2];
    evt_vec[pst_pkg::EVT_ANC] = an_complete_i & ~prev_reg[1];
    evt_vec[pst_pkg::EVT_FCAR_HALF] = fcar_half_i & ~half_reg[1];
    evt_vec[pst_pkg::EVT_RXERR_HALF] = rxerr_half_i & ~half_reg[0];
  end

  // Separate history for the two half-full flags, rising edge only
  always_comb begin
    half_next = {fcar_half_i, rxerr_half_i};
  end

  // ****************************************************************
  // Register next-state logic
  // ****************************************************************
  always_comb begin
    evt_read = reg_read_i & hit(reg_addr_i, pst_pkg::OFS_EVENT_IRQ_STATUS);
    ctrl_next = ctrl_reg;
    evt_en_next = evt_en_reg;
    // Writes land only in implemented bits; the rest is dropped
    if (reg_write_i) begin
      if (hit(reg_addr_i, pst_pkg::OFS_INTERRUPT_CONTROL)) begin
        ctrl_next = reg_wdata_i[pst_pkg::CTL_W-1:0];
      end else if (hit(reg_addr_i, pst_pkg::OFS_EVENT_IRQ_STATUS)) begin
        evt_en_next = reg_wdata_i[pst_pkg::EVT_N-1:0];
      end else begin
        // Summary status and unmapped addresses take no writes
      end
    end
    // Read clears pending flags, but a new event in that cycle still sets
    evt_stat_next = (evt_read ? '0 : evt_stat_reg) | evt_vec;
    // Pending is derived from the flags as they will stand
    irq_pend_next = ctrl_next[pst_pkg::CTL_TEST_IRQ_BIT]
                    | (ctrl_next[pst_pkg::CTL_EVENT_EN_BIT]
                       & (|(evt_stat_next & evt_en_next)));
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Summary status reads sample the live inputs, so reads never disturb them
  always_comb begin
    rdata_next = pst_pkg::RD_UNMAPPED;
    if (reg_read_i) begin
      if (hit(reg_addr_i, pst_pkg::OFS_SUMMARY_PHY_STATUS)) begin
        rdata_next[pst_pkg::SUM_JABBER_BIT] = jabber_i;
        rdata_next[pst_pkg::SUM_ANC_BIT] = an_complete_i;
        rdata_next[pst_pkg::SUM_LOOPBACK_BIT] = loopback_i;
        // Speed and duplex meaningful only with link; passed as given
        rdata_next[pst_pkg::SUM_DUPLEX_BIT] = full_duplex_i;
        rdata_next[pst_pkg::SUM_SPEED10_BIT] = speed10_i;
        rdata_next[pst_pkg::SUM_LINK_BIT] = link_i;
        rdata_next[pst_pkg::SUM_IRQ_PEND_BIT] = irq_pend_reg;
      end else if (hit(reg_addr_i, pst_pkg::OFS_INTERRUPT_CONTROL)) begin
        rdata_next[pst_pkg::CTL_W-1:0] = ctrl_reg;
      end else if (hit(reg_addr_i, pst_pkg::OFS_EVENT_IRQ_STATUS)) begin
        rdata_next[pst_pkg::EVT_STAT_LSB +: pst_pkg::EVT_N] = evt_stat_reg;
        rdata_next[pst_pkg::EVT_N-1:0] = evt_en_reg;
      end else begin
        // Unmapped address reads zero
      end
    end
  end

  // ****************************************************************
  // Shared pin
  // ****************************************************************
  // Pin is driven low for an interrupt; as an input, low asks for power-down
  always_comb begin
    pin_oe_next = ctrl_reg[pst_pkg::CTL_PIN_OE_BIT];
    pin_out_next = ~(ctrl_reg[pst_pkg::CTL_PIN_OE_BIT] & irq_pend_reg);
    // Own drive must not be read back as a power-down request
    pd_req_next = ~ctrl_reg[pst_pkg::CTL_PIN_OE_BIT] & ~pin_sync;
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_reg <= pst_pkg::CTL_RESET;
      evt_en_reg <= pst_pkg::EVT_RESET;
      evt_stat_reg <= pst_pkg::EVT_RESET;
      irq_pend_reg <= 1'b0;
      prev_reg <= '0;
      half_reg <= '0;
      rdata_reg <= pst_pkg::RD_UNMAPPED;
      pin_out_reg <= 1'b1;
      pin_oe_reg <= 1'b0;
      pd_req_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      evt_en_reg <= evt_en_next;
      evt_stat_reg <= evt_stat_next;
      irq_pend_reg <= irq_pend_next;
      prev_reg <= prev_next;
      half_reg <= half_next;
      rdata_reg <= rdata_next;
      pin_out_reg <= pin_out_next;
      pin_oe_reg <= pin_oe_next;
      pd_req_reg <= pd_req_next;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign powerdown_irq_pin_o = pin_out_reg;
  assign powerdown_irq_pin_oe_o = pin_oe_reg;
  assign powerdown_req_o = pd_req_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_jabber_mirror: assert property (
    (reg_read_i && reg_addr_i == pst_pkg::OFS_SUMMARY_PHY_STATUS)
    |=> reg_rdata_o[pst_pkg::SUM_JABBER_BIT] == $past(jabber_i)
  ) else $error("jabber bit does not follow basic status");

  a_link_mirror: assert property (
    (reg_read_i && reg_addr_i == pst_pkg::OFS_SUMMARY_PHY_STATUS) ##1
    (reg_read_i && reg_addr_i == pst_pkg::OFS_SUMMARY_PHY_STATUS && $stable(link_i))
    |=> reg_rdata_o[pst_pkg::SUM_LINK_BIT] == $past(link_i, 2)
  ) else $error("link bit changed by a summary read");

  a_status_fields: assert property (
    (reg_read_i && reg_addr_i == pst_pkg::OFS_SUMMARY_PHY_STATUS)
    |=> reg_rdata_o[4:1] == {$past(an_complete_i), $past(loopback_i),
                             $past(full_duplex_i), $past(speed10_i)}
  ) else $error("summary status fields misplaced");

  a_ctrl_reserved: assert property (
    (reg_read_i && reg_addr_i == pst_pkg::OFS_INTERRUPT_CONTROL)
    |=> reg_rdata_o[15:3] == 13'h0000
  ) else $error("reserved control bits read non-zero");

  a_test_irq_pin: assert property (
    (reg_write_i && reg_addr_i == pst_pkg::OFS_INTERRUPT_CONTROL && reg_wdata_i[2:0] == 3'h5)
    ##1 (!reg_write_i) [*3]
    |-> !powerdown_irq_pin_o && powerdown_irq_pin_oe_o
  ) else $error("test interrupt did not drive the pin");

  a_event_gate: assert property (
    (!ctrl_reg[pst_pkg::CTL_EVENT_EN_BIT] && !ctrl_reg[pst_pkg::CTL_TEST_IRQ_BIT]
     && !reg_write_i) |=> !irq_pend_reg ##1 powerdown_irq_pin_o
  ) else $error("event interrupt raised while disabled");

  a_pin_role: assert property (
    ##1 powerdown_irq_pin_oe_o == $past(ctrl_reg[pst_pkg::CTL_PIN_OE_BIT])
  ) else $error("pin direction does not follow control bit");

  a_event_sticky: assert property (
    (link_i != prev_reg[4]) |=> evt_stat_reg[pst_pkg::EVT_LINK]
  ) else $error("link change not latched");

  a_read_clears: assert property (
    (evt_read && evt_vec == 7'h00) |=> evt_stat_reg == 7'h00
  ) else $error("event read did not clear flags");

  a_reset_zero: assert property (
    disable iff (1'b0) $past(reset_i) |-> ctrl_reg == 3'h0 && evt_stat_reg == 7'h00
  ) else $error("bank not zero after reset");

  // Read data must fall back to zero, or a late sampler sees stale words
  a_rdata_idle: assert property (
    !reg_read_i |=> reg_rdata_o == 16'h0000
  ) else $error("read data not zero outside a read");

  // While the block drives the pin its own level is no power-down request
  a_pd_own_drive: assert property (
    ctrl_reg[pst_pkg::CTL_PIN_OE_BIT] |=> !powerdown_req_o
  ) else $error("power-down request while pin is an output");

  // An event read with nothing new and no test force drops pending
  a_pend_clear: assert property (
    (evt_read && evt_vec == 7'h00 && !ctrl_reg[pst_pkg::CTL_TEST_IRQ_BIT] && !reg_write_i)
    |=> !irq_pend_reg
  ) else $error("pending interrupt survived an event read");

  // An enabled flag with event interrupts on must keep pending raised
  a_pend_event: assert property (
    (ctrl_reg[pst_pkg::CTL_EVENT_EN_BIT] && !reg_write_i && !evt_read
     && (|(evt_stat_reg & evt_en_reg))) |=> irq_pend_reg
  ) else $error("enabled event did not raise pending");

endmodule // pst_status_irq
`default_nettype wire

/* File: rtl/pst_pkg.sv */
// ****************************************************************
// Constants shared by the status and interrupt control bank
// ****************************************************************
`default_nettype none
package pst_pkg;

  // Management address and data widths
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;

  // Register offsets in management address space
  localparam logic [4:0] OFS_SUMMARY_PHY_STATUS = 5'h10; // Summary status, read only
  localparam logic [4:0] OFS_INTERRUPT_CONTROL = 5'h11; // Interrupt control
  localparam logic [4:0] OFS_EVENT_IRQ_STATUS = 5'h12; // Event status and enables

  // Summary status field positions
  localparam int unsigned SUM_LINK_BIT = 0;
  localparam int unsigned SUM_SPEED10_BIT = 1;
  localparam int unsigned SUM_DUPLEX_BIT = 2;
  localparam int unsigned SUM_LOOPBACK_BIT = 3;
  localparam int unsigned SUM_ANC_BIT = 4;
  localparam int unsigned SUM_JABBER_BIT = 5;
  localparam int unsigned SUM_IRQ_PEND_BIT = 7;

  // Interrupt control field positions and writable mask
  localparam int unsigned CTL_PIN_OE_BIT = 0;
  localparam int unsigned CTL_EVENT_EN_BIT = 1;
  localparam int unsigned CTL_TEST_IRQ_BIT = 2;
  localparam int unsigned CTL_W = 3;
  localparam logic [2:0] CTL_RESET = 3'h0;

  // Event numbering: status sits at bit EVT_STAT_LSB + n, enable at bit n
  localparam int unsigned EVT_N = 7;
  localparam int unsigned EVT_RXERR_HALF = 0;
  localparam int unsigned EVT_FCAR_HALF = 1;
  localparam int unsigned EVT_ANC = 2;
  localparam int unsigned EVT_DUPLEX = 3;
  localparam int unsigned EVT_SPEED = 4;
  localparam int unsigned EVT_LINK = 5;
  localparam int unsigned EVT_ENERGY = 6;
  localparam int unsigned EVT_STAT_LSB = 8;
  localparam logic [6:0] EVT_RESET = 7'h00;

  // Read value of an unmapped address
  localparam logic [15:0] RD_UNMAPPED = 16'h0000;

endpackage : pst_pkg
`default_nettype wire

/* File: rtl/pst_sync2.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Two flip-flop synchroniser for levels arriving from a pin
// ****************************************************************
module pst_sync2 #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg; // First stage, read only by second stage
  logic [WIDTH-1:0] sync_reg; // Second stage, safe to use
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_next;

  // Next values of both stages
  always_comb begin
    meta_next = async_i;
    sync_next = meta_reg;
  end

  // Both stages load the reset level so the pin looks idle after reset
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta_reg <= INIT;
      sync_reg <= INIT;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_o = sync_reg;

endmodule // pst_sync2
`default_nettype wire

/* File: test/pst_mgmt_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Management controller model driving the register port
// ****************************************************************
module pst_mgmt_model (
  input wire logic clk_i,
  input wire logic [15:0] reg_rdata_i,
  output logic [4:0] reg_addr_o,
  output logic [15:0] reg_wdata_o,
  output logic reg_write_o,
  output logic reg_read_o
);
  // Idle bus at time zero
  initial begin
    reg_addr_o = 5'h00;
    reg_wdata_o = 16'h0000;
    reg_write_o = 1'b0;
    reg_read_o = 1'b0;
  end

  // One-cycle write; address and data are inverted once released
  // so a design that samples late sees garbage, not a stale match
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_write_o <= 1'b1;
    @(posedge clk_i);
    reg_write_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask

  // One-cycle read; data is taken only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_read_o <= 1'b1;
    @(posedge clk_i);
    reg_read_o <= 1'b0;
    reg_addr_o <= ~a;
    #1;
    d = reg_rdata_i;
  endtask
endmodule // pst_mgmt_model
`default_nettype wire

/* File: test/pst_status_irq_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Self-checking bench for the status and interrupt control bank
// ****************************************************************
module pst_status_irq_tb_top;
  logic clk_i; // 50 MHz bench clock
  logic reset_i; // Synchronous reset
  logic [8:0] st; // Bits 6:0 event inputs by event number, 7 jabber, 8 loopback
  logic pin_ext; // Level applied by the board while the pin is an input
  logic [4:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [15:0] v;
  logic wr_s;
  logic rd_s;
  logic pin_o;
  logic pin_oe;
  logic pd_req;
  wire logic pin_w; // Resolved pin level
  int fails;
  int n_checks;
  int cyc;
  int seed;
  int n;

  // Pin level: the block wins while it drives, the board otherwise
  assign pin_w = pin_oe ? pin_o : pin_ext;

  pst_mgmt_model mgmt (.clk_i(clk_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_write_o(wr_s), .reg_read_o(rd_s));

  pst_status_irq uut (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_write_i(wr_s), .reg_read_i(rd_s), .reg_rdata_o(rdata),
    .jabber_i(st[7]), .link_i(st[5]), .an_complete_i(st[2]), .loopback_i(st[8]),
    .full_duplex_i(st[3]), .speed10_i(st[4]), .energy_i(st[6]), .fcar_half_i(st[1]),
    .rxerr_half_i(st[0]), .powerdown_irq_pin_i(pin_w), .powerdown_irq_pin_o(pin_o),
    .powerdown_irq_pin_oe_o(pin_oe), .powerdown_req_o(pd_req));

  // Clock generator
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end

  // Expected summary word from the live levels and the pending flag
  function automatic logic [15:0] sum_exp(input logic [8:0] s, input logic p);
    return {8'h00, p, 1'b0, s[7], s[2], s[8], s[3], s[4], s[5]};
  endfunction

  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Read one register and compare
  task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    mgmt.rd(a, d);
    chk(d, exp);
  endtask

  // Wait edges, then step past the edge so outputs have settled
  task automatic wt(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  // Verdict and end of run
  task automatic finish_test();
    if (fails == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    st = 9'h000;
    pin_ext = 1'b1;
    reset_i = 1'b1;
    fails = 0;
    n_checks = 0;
    cyc = 0;
    seed = 86;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    wt(1);
    // Everything idle after reset
    rdc(pst_pkg::OFS_SUMMARY_PHY_STATUS, 16'h0000);
    rdc(pst_pkg::OFS_INTERRUPT_CONTROL, 16'h0000);
    rdc(pst_pkg::OFS_EVENT_IRQ_STATUS, 16'h0000);
    // Status half and bit 7 of the event register take no writes
    mgmt.wr(pst_pkg::OFS_EVENT_IRQ_STATUS, 16'hFF80);
    rdc(pst_pkg::OFS_EVENT_IRQ_STATUS, 16'h0000);
    chk({14'h0000, pin_oe, pin_o}, 16'h0001);
    // Random live levels; a second read shows that reading never clears
    for (n = 0; n < 8; n++) begin
      @(posedge clk_i);
      st <= 9'($random(seed));
      wt(3);
      rdc(pst_pkg::OFS_SUMMARY_PHY_STATUS, sum_exp(st, 1'b0));
      rdc(pst_pkg::OFS_SUMMARY_PHY_STATUS, sum_exp(st, 1'b0));
    end
    // Reserved control bits drop writes and read zero
    for (n = 0; n < 4; n++) begin
      v = 16'($random(seed));
      mgmt.wr(pst_pkg::OFS_INTERRUPT_CONTROL, v);
      rdc(pst_pkg::OFS_INTERRUPT_CONTROL, v & 16'h0007);
    end
    mgmt.wr(pst_pkg::OFS_INTERRUPT_CONTROL, 16'h0000);
    mgmt.wr(pst_pkg::OFS_SUMMARY_PHY_STATUS, 16'hFFFF);
    rdc(pst_pkg::OFS_SUMMARY_PHY_STATUS, sum_exp(st, 1'b0));
    rdc(5'h1F, pst_pkg::RD_UNMAPPED);
    // Test interrupt drives the pin for as long as it stays set
    mgmt.wr(pst_pkg::OFS_INTERRUPT_CONTROL, 16'h0005);
    wt(3);
    chk({14'h0000, pin_oe, pin_o}, 16'h0002);
    wt(6);
    chk({15'h0000, pin_o}, 16'h0000);
    rdc(pst_pkg::OFS_SUMMARY_PHY_STATUS, sum_exp(st, 1'b1));
    mgmt.wr(pst_pkg::OFS_INTERRUPT_CONTROL, 16'h0001);
    wt(3);
    chk({15'h0000, pin_o}, 16'h0001);
    // Every event source: latched while disabled, interrupts once enabled
    @(posedge clk_i);
    st <= 9'h000;
    wt(4);
    for (n = 0; n < 7; n++) begin
      mgmt.wr(pst_pkg::OFS_EVENT_IRQ_STATUS, 16'h0000);
      mgmt.rd(pst_pkg::OFS_EVENT_IRQ_STATUS, v);
      mgmt.wr(pst_pkg::OFS_INTERRUPT_CONTROL, 16'h0003);
      @(posedge clk_i);
      st[n] <= 1'b1;
      wt(4);
      chk({15'h0000, pin_o}, 16'h0001);
      rdc(pst_pkg::OFS_EVENT_IRQ_STATUS, 16'(1 << (8 + n)));
      rdc(pst_pkg::OFS_EVENT_IRQ_STATUS, 16'h0000);
      @(posedge clk_i);
      st[n] <= 1'b0;
      wt(4);
      mgmt.rd(pst_pkg::OFS_EVENT_IRQ_STATUS, v);
      mgmt.wr(pst_pkg::OFS_EVENT_IRQ_STATUS, 16'(1 << n));
      @(posedge clk_i);
      st[n] <= 1'b1;
      wt(4);
      chk({15'h0000, pin_o}, 16'h0000);
      rdc(pst_pkg::OFS_SUMMARY_PHY_STATUS, sum_exp(st, 1'b1));
      mgmt.wr(pst_pkg::OFS_INTERRUPT_CONTROL, 16'h0001);
      wt(3);
      chk({15'h0000, pin_o}, 16'h0001);
      mgmt.wr(pst_pkg::OFS_INTERRUPT_CONTROL, 16'h0003);
      wt(3);
      chk({15'h0000, pin_o}, 16'h0000);
      mgmt.rd(pst_pkg::OFS_EVENT_IRQ_STATUS, v);
      wt(3);
      chk({15'h0000, pin_o}, 16'h0001);
      @(posedge clk_i);
      st[n] <= 1'b0;
      wt(4);
    end
    // Pin as power-down input only while output enable is clear
    mgmt.wr(pst_pkg::OFS_INTERRUPT_CONTROL, 16'h0000);
    @(posedge clk_i);
    pin_ext <= 1'b0;
    wt(4);
    chk({14'h0000, pin_oe, pd_req}, 16'h0001);
    @(posedge clk_i);
    pin_ext <= 1'b1;
    wt(4);
    chk({15'h0000, pd_req}, 16'h0000);
    mgmt.wr(pst_pkg::OFS_INTERRUPT_CONTROL, 16'h0001);
    pin_ext <= 1'b0;
    wt(4);
    chk({14'h0000, pin_oe, pd_req}, 16'h0002);
    @(posedge clk_i);
    pin_ext <= 1'b1;
    // Reset in mid-run clears control again
    mgmt.wr(pst_pkg::OFS_INTERRUPT_CONTROL, 16'h0007);
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    wt(1);
    rdc(pst_pkg::OFS_INTERRUPT_CONTROL, 16'h0000);
    chk({14'h0000, pin_oe, pin_o}, 16'h0001);
    finish_test();
  end
endmodule // pst_status_irq_tb_top
`default_nettype wire
